// File: wpf_flag_logic.sv
/*
  Write-port status flag logic: shared full flag, almost-full flag bus in
  direct and polled mode, token chain, interrupts and an AXI4-Lite slave.
  Assumes every input is synchronous to aclk and the per-queue full and
  almost-full status vectors come from the queue bookkeeping elsewhere.
*/
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module wpf_flag_logic
  import wpf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] write_queue_address_bus,
  input wire logic write_address_enable,
  input wire logic flag_bus_mode_select,
  input wire logic almost_full_bus_strobe,
  input wire logic serial_program_output,
  input wire logic almost_full_token_in,
  input wire logic [NUM_QUEUES-1:0] queue_full_status,
  input wire logic [NUM_QUEUES-1:0] queue_almost_full_status,
  output logic queue_full_flag,
  output logic queue_full_flag_oe,
  output logic [WORD_W-1:0] almost_full_flag_bus,
  output logic almost_full_bus_sync,
  output logic almost_full_token_out,
  output logic irq,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Software state.
  logic [DEV_W-1:0] dev_id;
  logic [DEV_W-1:0] next_dev_id;
  logic poll_lead;
  logic next_poll_lead;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_irq_mask;
  logic next_irq;

  // Bus slave state.
  logic aw_held;
  logic next_aw_held;
  logic w_held;
  logic next_w_held;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic [AXI_ADDR_W-1:0] next_aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [DATA_W-1:0] next_w_data;
  logic [DATA_W/8-1:0] w_strb;
  logic [DATA_W/8-1:0] next_w_strb;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0] next_rresp;
  logic wr_fire;

  // Flag bus state.
  logic polled;
  logic next_polled;
  logic start_pending;
  logic next_start_pending;
  wpf_poll_t poll_state;
  wpf_poll_t next_poll_state;
  logic [WSEL_W-1:0] word;
  logic [WSEL_W-1:0] next_word;
  logic [WORD_W-1:0] next_bus;
  logic next_sync;
  logic next_token;

  // Decoded selection and strobe.
  logic addr_mine;
  logic sel_mine;
  logic sel_other;
  logic strobe_ok;
  logic strobe_bad;
  logic owned;
  logic [QUEUE_W-1:0] cur_queue;
  logic flag_prev;
  logic poll_start;
  logic wrap_event;

  // Selection decode: the upper address bits name the device that owns the queue.
  always_comb
  begin
    addr_mine = (write_queue_address_bus[DEV_LSB +: DEV_W] == dev_id);
    sel_mine = write_address_enable && addr_mine;
    sel_other = write_address_enable && !addr_mine;
    // A strobe in polled mode or while programming runs is ignored and flagged.
    strobe_ok = almost_full_bus_strobe && !polled && !serial_program_output;
    strobe_bad = almost_full_bus_strobe && (polled || serial_program_output);
  end

  wpf_full_flag u_full_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel_mine(sel_mine),
    .sel_other(sel_other),
    .sel_queue(write_queue_address_bus[QUEUE_W-1:0]),
    .queue_full_status(queue_full_status),
    .owned(owned),
    .cur_queue(cur_queue),
    .queue_full_flag(queue_full_flag),
    .queue_full_flag_oe(queue_full_flag_oe)
  );

  // Almost-full bus: direct loads on strobe, polled rotates through the four words.
  // A device only enters the rotation on the token or, for the chain leader,
  // once after reset; the leader bit must be set on exactly one device.
  always_comb
  begin
    // The mode pin is caught while reset is held and frozen afterwards.
    next_polled = aresetn ? polled : flag_bus_mode_select;
    next_start_pending = start_pending;
    next_poll_state = poll_state;
    next_word = word;
    next_bus = almost_full_flag_bus;
    next_sync = 1'b0;
    next_token = 1'b0;
    wrap_event = 1'b0;
    poll_start = polled && (almost_full_token_in || (start_pending && poll_lead));
    if (!polled)
    begin
      next_poll_state = WPF_POLL_IDLE;
      if (strobe_ok)
      begin
        // Word index sits in the low address bits, eight queues per word.
        next_bus = queue_almost_full_status[32'(write_queue_address_bus[WSEL_W-1:0])
                   * WORD_W +: WORD_W];
      end
    end
    else
    begin
      case (poll_state)
        WPF_POLL_IDLE:
        begin
          if (poll_start)
          begin
            next_start_pending = 1'b0;
            next_poll_state = WPF_POLL_RUN;
            next_word = FIRST_WORD;
            next_sync = 1'b1;
          end
        end
        WPF_POLL_RUN:
        begin
          if (word != LAST_WORD)
          begin
            next_word = word + WORD_STEP;
            next_token = (next_word == LAST_WORD); // Pulse with the fourth word.
          end
          else if (poll_start)
          begin
            next_word = FIRST_WORD; // Fifth edge is word one again.
            next_sync = 1'b1;
            wrap_event = 1'b1;
          end
          else
          begin
            next_poll_state = WPF_POLL_IDLE; // Token handed on; another device owns the bus.
          end
        end
        default:
        begin
          next_poll_state = WPF_POLL_IDLE;
        end
      endcase
      if (next_poll_state == WPF_POLL_RUN)
      begin
        next_bus = queue_almost_full_status[32'(next_word) * WORD_W +: WORD_W];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      polled <= next_polled;
      start_pending <= 1'b1;
      poll_state <= WPF_POLL_IDLE;
      word <= FIRST_WORD;
      almost_full_flag_bus <= '0;
      almost_full_bus_sync <= 1'b0;
      almost_full_token_out <= 1'b0;
      flag_prev <= 1'b0;
    end
    else
    begin
      polled <= next_polled;
      start_pending <= next_start_pending;
      poll_state <= next_poll_state;
      word <= next_word;
      almost_full_flag_bus <= next_bus;
      almost_full_bus_sync <= next_sync;
      almost_full_token_out <= next_token;
      flag_prev <= queue_full_flag;
    end
  end

  // Register bus: address and data are taken in either order, then one response.
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_dev_id = dev_id;
    next_poll_lead = poll_lead;
    next_irq_mask = irq_mask;
    wr_fire = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !s_axi_bvalid)
    begin
      wr_fire = w_strb[0];
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (aw_addr)
        REG_CTRL:
        begin
          if (w_strb[0])
          begin
            next_dev_id = w_data[CTRL_DEV_LSB +: DEV_W];
            next_poll_lead = w_data[CTRL_LEAD_BIT];
          end
        end
        REG_IRQ_MASK:
        begin
          if (w_strb[0])
          begin
            next_irq_mask = w_data[IRQ_W-1:0];
          end
        end
        REG_STATUS, REG_IRQ_STATUS:
        begin
          next_bresp = RESP_OKAY;
        end
        default:
        begin
          next_bresp = RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
  end

  // Read channel: one read in flight; rvalid holds until rready.
  always_comb
  begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      case (s_axi_araddr)
        REG_CTRL:
        begin
          next_rdata[CTRL_DEV_LSB +: DEV_W] = dev_id;
          next_rdata[CTRL_LEAD_BIT] = poll_lead;
        end
        REG_STATUS:
        begin
          next_rdata[STAT_POLLED_BIT] = polled;
          next_rdata[STAT_OWNED_BIT] = owned;
          next_rdata[STAT_FLAG_BIT] = queue_full_flag;
          next_rdata[STAT_RUN_BIT] = (poll_state == WPF_POLL_RUN);
          next_rdata[STAT_WORD_LSB +: WSEL_W] = word;
          next_rdata[STAT_QUEUE_LSB +: QUEUE_W] = cur_queue;
        end
        REG_IRQ_STATUS:
        begin
          next_rdata[IRQ_W-1:0] = irq_status;
        end
        REG_IRQ_MASK:
        begin
          next_rdata[IRQ_W-1:0] = irq_mask;
        end
        default:
        begin
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
  end

  // Sticky events; a set in the same cycle as a write-one clear wins.
  always_comb
  begin
    next_irq_status = irq_status;
    if (wr_fire && aw_addr == REG_IRQ_STATUS)
    begin
      next_irq_status = irq_status & ~w_data[IRQ_W-1:0];
    end
    if (sel_mine)
    begin
      next_irq_status[IRQ_QSEL] = 1'b1;
    end
    // The owned queue just reported full: the writer must stop.
    if (owned && flag_prev && !queue_full_flag)
    begin
      next_irq_status[IRQ_FULL] = 1'b1;
    end
    if (wrap_event)
    begin
      next_irq_status[IRQ_WRAP] = 1'b1;
    end
    if (strobe_bad)
    begin
      next_irq_status[IRQ_STRB_ERR] = 1'b1;
    end
    next_irq = |(next_irq_status & irq_mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      dev_id <= CTRL_DEV_RST;
      poll_lead <= CTRL_LEAD_RST;
      irq_status <= IRQ_RST;
      irq_mask <= IRQ_RST;
      irq <= 1'b0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      dev_id <= next_dev_id;
      poll_lead <= next_poll_lead;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
    end
  end

endmodule : wpf_flag_logic

`default_nettype wire

// File: wpf_pkg.sv
/*
  Shared constants for the write-port flag logic: queue address layout,
  status word layout, register map and field positions.
  Assumes a single write clock domain and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none

package wpf_pkg;

  // Queue address bus layout: upper bits pick the device, lower bits the queue.
  localparam int ADDR_W = 8;
  localparam int DEV_W = 3;
  localparam int QUEUE_W = 5;
  localparam int DEV_LSB = 5;
  localparam int NUM_QUEUES = 32;

  // Almost-full status words: four words of eight queues each.
  localparam int WORD_W = 8;
  localparam int NUM_WORDS = 4;
  localparam int WSEL_W = 2;
  localparam logic [WSEL_W-1:0] FIRST_WORD = 2'h0;
  localparam logic [WSEL_W-1:0] LAST_WORD = 2'h3;
  localparam logic [WSEL_W-1:0] WORD_STEP = 2'h1;

  // Register bus.
  localparam int AXI_ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [AXI_ADDR_W-1:0] REG_IRQ_STATUS = 4'h8;
  localparam logic [AXI_ADDR_W-1:0] REG_IRQ_MASK = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register fields and reset values.
  localparam int CTRL_DEV_LSB = 0;
  localparam int CTRL_LEAD_BIT = 3;
  localparam logic [DEV_W-1:0] CTRL_DEV_RST = 3'h0;
  localparam logic CTRL_LEAD_RST = 1'b1;

  // Status register fields.
  localparam int STAT_POLLED_BIT = 0;
  localparam int STAT_OWNED_BIT = 1;
  localparam int STAT_FLAG_BIT = 2;
  localparam int STAT_RUN_BIT = 3;
  localparam int STAT_WORD_LSB = 4;
  localparam int STAT_QUEUE_LSB = 8;

  // Interrupt status and mask layout.
  localparam int IRQ_W = 4;
  localparam int IRQ_QSEL = 0;
  localparam int IRQ_FULL = 1;
  localparam int IRQ_WRAP = 2;
  localparam int IRQ_STRB_ERR = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

  typedef enum logic {WPF_POLL_IDLE, WPF_POLL_RUN} wpf_poll_t;

endpackage : wpf_pkg

`default_nettype wire

// File: wpf_full_flag.sv
/*
  Full flag output stage for the write port: ownership of the shared flag
  line and the pipeline that shows the newly selected queue's status.
  Assumes selections arrive already decoded against this device's number.
*/
`timescale 1ns/1ns
`default_nettype none

module wpf_full_flag
  import wpf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sel_mine,
  input wire logic sel_other,
  input wire logic [QUEUE_W-1:0] sel_queue,
  input wire logic [NUM_QUEUES-1:0] queue_full_status,
  output logic owned,
  output logic [QUEUE_W-1:0] cur_queue,
  output logic queue_full_flag,
  output logic queue_full_flag_oe
);

  logic next_owned;
  logic [QUEUE_W-1:0] next_cur_queue;
  logic stage;
  logic next_stage;
  logic next_flag;
  logic next_oe;

  // Selection edge captures the queue; one edge later the status is sampled, one more
  // edge and the pin shows it, so the third cycle after selection is valid.
  always_comb
  begin
    next_owned = owned;
    next_cur_queue = cur_queue;
    if (sel_mine)
    begin
      next_owned = 1'b1;
      next_cur_queue = sel_queue;
    end
    else if (sel_other)
    begin
      next_owned = 1'b0; // Another device takes the shared line.
    end
    next_oe = next_owned; // Drive starts the cycle after the selection.
    next_stage = ~queue_full_status[cur_queue]; // High means room left.
    next_flag = stage;
  end

  // Only the write clock moves the flag; no other clock reaches it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      owned <= 1'b0;
      cur_queue <= '0;
      stage <= 1'b0;
      queue_full_flag <= 1'b0;
      queue_full_flag_oe <= 1'b0;
    end
    else
    begin
      owned <= next_owned;
      cur_queue <= next_cur_queue;
      stage <= next_stage;
      queue_full_flag <= next_flag;
      queue_full_flag_oe <= next_oe;
    end
  end

endmodule : wpf_full_flag

`default_nettype wire

// File: wpf_checker.sv
/*
  Checker for the write-port flag logic: full flag ownership and timing,
  direct loads and the polled word rotation of the almost-full bus.
  Assumes device number 0 and a single device looping its own token.
*/
`timescale 1ns/1ns
`default_nettype none

module wpf_checker
  import wpf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] write_queue_address_bus,
  input wire logic write_address_enable,
  input wire logic flag_bus_mode_select,
  input wire logic almost_full_bus_strobe,
  input wire logic serial_program_output,
  input wire logic almost_full_token_in,
  input wire logic [NUM_QUEUES-1:0] queue_full_status,
  input wire logic [NUM_QUEUES-1:0] queue_almost_full_status,
  input wire logic queue_full_flag,
  input wire logic queue_full_flag_oe,
  input wire logic [WORD_W-1:0] almost_full_flag_bus,
  input wire logic almost_full_bus_sync,
  input wire logic almost_full_token_out
);
  logic polled, next_polled, mine;
  logic [QUEUE_W-1:0] cur_q, next_cur_q;
  logic [NUM_QUEUES-1:0] st1, st2, afs_d;
  logic [1:0] widx_d;

  // Only device 0 exists here, so a selection is ours when its device field is zero.
  assign mine = write_address_enable && (write_queue_address_bus[7:5] == 3'h0);

  // Mode is captured during reset just like the design; queue follows own selections.
  always_comb
  begin
    next_polled = aresetn ? polled : flag_bus_mode_select;
    next_cur_q = mine ? write_queue_address_bus[QUEUE_W-1:0] : cur_q;
  end

  // Two stages of status history line up with the flag's two-edge latency.
  always_ff @(posedge aclk)
  begin
    polled <= next_polled;
    cur_q <= next_cur_q;
    st1 <= queue_full_status;
    st2 <= st1;
    // Last edge's status vector and word index, for the bus loaded at that edge.
    afs_d <= queue_almost_full_status;
    widx_d <= write_queue_address_bus[1:0];
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  oe_take_a: assert property (mine |=> queue_full_flag_oe)
    else $error("full flag not driven after own selection");
  oe_give_a: assert property (write_address_enable && !mine |=> !queue_full_flag_oe)
    else $error("full flag still driven after foreign selection");
  oe_hold_a: assert property (!write_address_enable |=> $stable(queue_full_flag_oe))
    else $error("full flag enable moved without selection");
  flag_val_a: assert property (
    (queue_full_flag_oe && !$past(write_address_enable) && !$past(write_address_enable, 2))
    |-> queue_full_flag == !st2[cur_q])
    else $error("full flag does not match selected queue");
  direct_load_a: assert property (
    !polled && almost_full_bus_strobe && !serial_program_output
    |=> almost_full_flag_bus == afs_d[{widx_d, 3'h0} +: WORD_W])
    else $error("direct strobe loaded wrong word");
  direct_hold_a: assert property (
    !polled && !(almost_full_bus_strobe && !serial_program_output)
    |=> $stable(almost_full_flag_bus))
    else $error("flag bus moved without accepted strobe");
  sync_word_a: assert property (
    almost_full_bus_sync |-> polled && almost_full_flag_bus == afs_d[7:0])
    else $error("sync high without first word");
  poll_seq_a: assert property (
    almost_full_bus_sync
    |=> (!almost_full_bus_sync && almost_full_flag_bus == afs_d[15:8])
    ##1 (!almost_full_bus_sync && almost_full_flag_bus == afs_d[23:16])
    ##1 (almost_full_token_out && almost_full_flag_bus == afs_d[31:24]))
    else $error("polled word order broken");
  wrap_a: assert property (
    almost_full_token_out && almost_full_token_in |=> almost_full_bus_sync)
    else $error("no wrap to first word after token");
  token_mode_a: assert property (almost_full_token_out |-> polled)
    else $error("token pulse in direct mode");
endmodule : wpf_checker

bind wpf_flag_logic wpf_checker u_chk (.aclk, .aresetn, .write_queue_address_bus,
  .write_address_enable, .flag_bus_mode_select, .almost_full_bus_strobe,
  .serial_program_output, .almost_full_token_in, .queue_full_status,
  .queue_almost_full_status, .queue_full_flag, .queue_full_flag_oe,
  .almost_full_flag_bus, .almost_full_bus_sync, .almost_full_token_out);

`default_nettype wire

// File: wpf_partner.sv
/*
  Far-side model: the write-side controller of a single-device chain.
  Assumes the bench holds the mode pin and asks for programming.
*/
`timescale 1ns/1ns
`default_nettype none

module wpf_partner
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic polled,
  input wire logic prog_req,
  input wire logic almost_full_token_out,
  output logic almost_full_token_in,
  output var logic serial_program_output
);
  // A lone device feeds its own token back in polled mode; direct mode keeps it low.
  assign almost_full_token_in = polled & almost_full_token_out;

  // Programming runs through reset and whenever asked; a strobe during it is refused, not held back.
  always_ff @(posedge aclk)
  begin
    serial_program_output <= !aresetn || prog_req;
  end
endmodule : wpf_partner

`default_nettype wire

// File: tb_top.sv
/*
  Testbench for the write-port flag logic: registers, full flag, direct
  strobes, a refused strobe with interrupt, and polled rotation.
  Assumes the partner model and checker files are compiled beforehand.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top
  import wpf_pkg::*;
;
  logic aclk = 1'h0, aresetn = 1'h0, write_address_enable = 1'h0, prog_req = 1'h0;
  logic flag_bus_mode_select = 1'h0, almost_full_bus_strobe = 1'h0;
  logic [7:0] write_queue_address_bus = 8'h0;
  logic [31:0] queue_full_status = 32'h0, queue_almost_full_status = 32'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, afs;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic queue_full_flag, queue_full_flag_oe, almost_full_bus_sync, irq;
  logic almost_full_token_out, almost_full_token_in, serial_program_output;
  logic [7:0] almost_full_flag_bus, w;
  logic [7:0] exp_q[$];
  integer seed = 32'haec9;
  int fail_count = 0, total_checks = 0, n;

  wpf_flag_logic DUT (.aclk, .aresetn, .write_queue_address_bus, .write_address_enable,
    .flag_bus_mode_select, .almost_full_bus_strobe, .serial_program_output,
    .almost_full_token_in, .queue_full_status, .queue_almost_full_status, .queue_full_flag,
    .queue_full_flag_oe, .almost_full_flag_bus, .almost_full_bus_sync, .almost_full_token_out,
    .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  wpf_partner u_partner (.aclk, .aresetn, .polled(flag_bus_mode_select), .prog_req,
    .almost_full_token_out, .almost_full_token_in, .serial_program_output);

  // Free-running 250 MHz clock.
  always #2 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // The mode pin is set together with reset and then left alone.
  task automatic do_reset(input logic mode);
    @(posedge aclk);
    aresetn <= 1'h0;
    flag_bus_mode_select <= mode;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
  endtask : do_reset

  // Both address and data are offered together; each is dropped once taken.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    bit aw, wd;
    aw = 0;
    wd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && wd))
    begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (!wd && s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      aw |= (s_axi_awready === 1'h1);
      wd |= (s_axi_wready === 1'h1);
    end
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
    s_axi_bready <= 1'h0;
  endtask : axi_wr

  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] m,
                        input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    chk(nm, e, rd & m);
    chk("rresp", 32'(er), 32'(rs));
  endtask : rd_chk

  // Selection at one edge; enable shows a cycle later, the queue's flag three later.
  task automatic select(input logic [7:0] a, input logic [31:0] st);
    @(posedge aclk);
    write_queue_address_bus <= a;
    write_address_enable <= 1'h1;
    queue_full_status <= st;
    @(posedge aclk);
    write_address_enable <= 1'h0;
    @(posedge aclk);
    #1 chk("oe", 32'(a[7:5] == 3'h0), 32'(queue_full_flag_oe));
    @(posedge aclk);
    #1 if (a[7:5] == 3'h0) chk("flag", 32'(!st[a[4:0]]), 32'(queue_full_flag));
  endtask : select

  // Watchdog sized well past the two hundred or so cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    wrap_up();
  end

  initial
  begin
    do_reset(1'h0);
    rd_chk("ctrl", REG_CTRL, 32'hf, 32'h8, RESP_OKAY);
    rd_chk("mode", REG_STATUS, 32'h1, 32'h0, RESP_OKAY);
    rd_chk("mask", REG_IRQ_MASK, 32'hf, 32'h0, RESP_OKAY);
    rd_chk("hole", 4'h2, 32'h0, 32'h0, RESP_SLVERR);
    repeat (16)
      select({($random(seed) & 1) ? 3'h0 : 3'(1 + {$random(seed)} % 7),
              5'($random(seed))}, $random(seed));
    // Own queue 3 with room: owned, flag high, queue number in the status word.
    select(8'h03, 32'h0);
    rd_chk("status", REG_STATUS, 32'h1f06, 32'h306, RESP_OKAY);
    // The writer must stop once its queue fills; that moment is latched for software.
    axi_wr(REG_IRQ_STATUS, 32'h2);
    rd_chk("full clr", REG_IRQ_STATUS, 32'h2, 32'h0, RESP_OKAY);
    queue_full_status <= 32'h8;
    repeat (4) @(posedge aclk);
    rd_chk("full evt", REG_IRQ_STATUS, 32'h2, 32'h2, RESP_OKAY);
    // Back-to-back strobes: the first three words show for exactly one cycle each; the fourth holds.
    afs = $random(seed);
    @(posedge aclk);
    queue_almost_full_status <= afs;
    for (int k = 0; k < 6; k++)
    begin
      @(posedge aclk);
      if (k >= 2) chk("word", 32'(afs[8*(k-2) +: 8]), 32'(almost_full_flag_bus));
      almost_full_bus_strobe <= (k < 4);
      write_queue_address_bus <= 8'(($random(seed) << 2) | k);
    end
    // A strobe during programming must be refused and flagged.
    prog_req <= 1'h1;
    repeat (2) @(posedge aclk);
    almost_full_bus_strobe <= 1'h1;
    queue_almost_full_status <= ~afs;
    @(posedge aclk);
    almost_full_bus_strobe <= 1'h0;
    prog_req <= 1'h0;
    repeat (2) @(posedge aclk);
    #1 chk("held", 32'(afs[31:24]), 32'(almost_full_flag_bus));
    chk("irq masked", 32'h0, 32'(irq));
    axi_wr(REG_IRQ_MASK, 32'h8);
    rd_chk("mask", REG_IRQ_MASK, 32'hf, 32'h8, RESP_OKAY);
    rd_chk("irq st", REG_IRQ_STATUS, 32'h8, 32'h8, RESP_OKAY);
    repeat (2) @(posedge aclk);
    #1 chk("irq", 32'h1, 32'(irq));
    axi_wr(REG_IRQ_STATUS, 32'h8);
    repeat (2) @(posedge aclk);
    #1 chk("irq clr", 32'h0, 32'(irq));
    // Polled mode: strobe stays low, the token loops back through the partner.
    do_reset(1'h1);
    rd_chk("mode", REG_STATUS, 32'h1, 32'h1, RESP_OKAY);
    exp_q = {afs[7:0] ^ 8'hff, afs[15:8] ^ 8'hff, afs[23:16] ^ 8'hff, afs[31:24] ^ 8'hff};
    n = 0;
    while (almost_full_bus_sync !== 1'h1 && n < 40)
    begin
      @(posedge aclk);
      n++;
    end
    chk("sync seen", 32'h1, 32'(n < 40));
    for (int i = 0; i < 9; i++)
    begin
      w = exp_q.pop_front();
      exp_q.push_back(w);
      chk("poll word", 32'(w), 32'(almost_full_flag_bus));
      chk("sync", 32'(i % 4 == 0), 32'(almost_full_bus_sync));
      chk("token", 32'(i % 4 == 3), 32'(almost_full_token_out));
      @(posedge aclk);
    end
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
